// file: core/dac_device_end.sv
`timescale 1ns/1ns
// How it works
// - Input shift register holds sixteen bits.
// - Chip select low opens, high closes frame.
// - MSB first, sampled on serial clock rise.
// - Long frames keep the final sixteen bits.
// - Short frames shift older low bits to the top.
// - Serial clock up to fifty megahertz accepted.
// - Strobe low at frame start: load at end.
// - Strobe high in frame: wait for strobe fall.
// - Strobe falls ignored while chip select low.
// - Converter register cleared to zero at reset.
// - Converter register holds zero until first transfer.
// - Shift register has no reset value.
// - Host sends at least sixteen bits on first write.
// - Host overwrites input before first frame close.
// - Converter code is unsigned straight binary.
// - Top four bits thermometer, low twelve direct.
// - Host selects only one device at once.
// - Host gates serial clock to frames only.
// - Strobe tied low updates every frame end.
module dac_device_end (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   dac_link_if.device link,
   output logic [dac_link_pkg::WORD_W-1:0] code_o,
   output logic [dac_link_pkg::SEG_N-1:0] seg_o,
   output logic [dac_link_pkg::LADDER_W-1:0] ladder_o,
   output logic update_o,
   output logic pending_o,
   output logic frame_o
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   logic [dac_link_pkg::WORD_W-1:0] shift_ff;
   logic cs_meta_ff;
   logic cs_sync_ff;
   logic cs_prev_ff;
   logic ls_meta_ff;
   logic ls_sync_ff;
   logic ls_prev_ff;
   logic cs_fall;
   logic cs_rise;
   logic ls_fall;
   logic transfer;
   dac_link_pkg::dev_state_type state_ff;
   dac_link_pkg::dev_state_type nxt_state;
   logic [dac_link_pkg::WORD_W-1:0] code_ff;
   logic [dac_link_pkg::WORD_W-1:0] nxt_code;
   logic [dac_link_pkg::SEG_N-1:0] seg_ff;
   logic [dac_link_pkg::SEG_N-1:0] nxt_seg;
   logic update_ff;
   logic pending_ff;
   logic frame_ff;

   // -------------------------------------------------------------------------
   // Link domain: input shift register
   // -------------------------------------------------------------------------
   // The shift register runs only on the serial clock, which may stand still
   // between frames. It has no reset so that it powers up undefined, like the
   // real input register; the host must fill it before the first load.
   always_ff @(posedge link.sclk) begin
      if (!link.cs_n) begin
         // Shifting in from the bottom keeps the last sixteen bits of a long
         // frame and shifts the lower old bits of a short frame up to the top.
         shift_ff <= {shift_ff[dac_link_pkg::WORD_W-2:0], link.din};
      end
   end

   // -------------------------------------------------------------------------
   // System domain: pin synchronisers and edge detection
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         cs_meta_ff <= 1'b1;
         cs_sync_ff <= 1'b1;
         cs_prev_ff <= 1'b1;
      end else begin
         cs_meta_ff <= link.cs_n;
         cs_sync_ff <= cs_meta_ff;
         cs_prev_ff <= cs_sync_ff;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ls_meta_ff <= 1'b1;
         ls_sync_ff <= 1'b1;
         ls_prev_ff <= 1'b1;
      end else begin
         ls_meta_ff <= link.load_strobe_n;
         ls_sync_ff <= ls_meta_ff;
         ls_prev_ff <= ls_sync_ff;
      end
   end

   assign cs_fall = cs_prev_ff & ~cs_sync_ff;
   assign cs_rise = ~cs_prev_ff & cs_sync_ff;
   // A strobe fall only counts while chip select is seen high.
   assign ls_fall = ls_prev_ff & ~ls_sync_ff & cs_sync_ff & cs_prev_ff;

   // -------------------------------------------------------------------------
   // Load control
   // -------------------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      transfer = 1'b0;
      unique case (state_ff)
         dac_link_pkg::DEV_IDLE: begin
            if (cs_fall) begin
               // The strobe level at the start of the frame picks the mode.
               nxt_state = ls_sync_ff ? dac_link_pkg::DEV_FRAME_LATER : dac_link_pkg::DEV_FRAME_NOW;
            end
         end
         dac_link_pkg::DEV_FRAME_NOW: begin
            if (cs_rise) begin
               transfer = 1'b1;
               nxt_state = dac_link_pkg::DEV_IDLE;
            end
         end
         dac_link_pkg::DEV_FRAME_LATER: begin
            if (cs_rise) begin
               nxt_state = dac_link_pkg::DEV_PENDING;
            end
         end
         dac_link_pkg::DEV_PENDING: begin
            if (cs_fall) begin
               // A new frame overwrites the waiting word; its own mode rules.
               nxt_state = ls_sync_ff ? dac_link_pkg::DEV_FRAME_LATER : dac_link_pkg::DEV_FRAME_NOW;
            end else if (ls_fall) begin
               transfer = 1'b1;
               nxt_state = dac_link_pkg::DEV_IDLE;
            end
         end
         default: begin
            nxt_state = dac_link_pkg::DEV_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         state_ff <= dac_link_pkg::DEV_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // -------------------------------------------------------------------------
   // Converter register and switch controls
   // -------------------------------------------------------------------------
   // The shift register is read here only after chip select has been seen
   // high through the synchroniser, so no serial edge can move it while it is
   // copied. The host must keep its last clock edge well before the rise.
   assign nxt_code = transfer ? shift_ff : code_ff;

   seg_decoder u_seg_decoder (
      .top_i(nxt_code[dac_link_pkg::WORD_W-1:dac_link_pkg::LADDER_W]),
      .seg_o(nxt_seg)
   );

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         code_ff <= dac_link_pkg::CODE_RESET;
         seg_ff <= dac_link_pkg::SEG_RESET;
      end else begin
         code_ff <= nxt_code;
         seg_ff <= nxt_seg;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         update_ff <= 1'b0;
      end else begin
         update_ff <= transfer;
      end
   end

   // -------------------------------------------------------------------------
   // Status outputs
   // -------------------------------------------------------------------------
   // Both levels are registered so that no decode gate sits between a
   // flip-flop and the pin; the frame flag trails the synchroniser by a cycle.
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         pending_ff <= 1'b0;
      end else begin
         pending_ff <= (nxt_state == dac_link_pkg::DEV_PENDING);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         frame_ff <= 1'b0;
      end else begin
         frame_ff <= ~cs_sync_ff;
      end
   end

   assign code_o = code_ff;
   assign seg_o = seg_ff;
   assign ladder_o = code_ff[dac_link_pkg::LADDER_W-1:0];
   assign update_o = update_ff;
   assign pending_o = pending_ff;
   assign frame_o = frame_ff;

endmodule : dac_device_end

// file: core/dac_host_end.sv
`timescale 1ns/1ns
module dac_host_end (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   dac_link_if.host link,
   input wire logic start_i,
   input wire logic [dac_link_pkg::WORD_W-1:0] word_i,
   input wire logic [dac_link_pkg::BITS_W-1:0] nbits_i,
   input wire logic defer_i,
   input wire logic strobe_i,
   output logic busy_o,
   output logic done_o
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   dac_link_pkg::host_state_type state_ff;
   dac_link_pkg::host_state_type nxt_state;
   logic [dac_link_pkg::CNT_W-1:0] cnt_ff;
   logic [dac_link_pkg::CNT_W-1:0] limit;
   logic timer_done;
   logic [dac_link_pkg::BITS_W-1:0] bits_ff;
   logic [dac_link_pkg::WORD_W-1:0] word_ff;
   logic first_ff;
   logic cs_n_ff;
   logic sclk_ff;
   logic din_ff;
   logic ls_n_ff;
   logic done_ff;
   logic [dac_link_pkg::BITS_W-1:0] start_bits;

   function automatic logic bit_at(input logic [dac_link_pkg::WORD_W-1:0] w,
                                   input logic [dac_link_pkg::BITS_W-1:0] idx);
      // Bits beyond the word are sent as zeros ahead of it.
      bit_at = (idx < dac_link_pkg::WORD_W) ? w[idx[dac_link_pkg::SEG_IN_W-1:0]] : 1'b0;
   endfunction : bit_at

   // The first frame after reset is stretched to a full word so no undefined
   // power-up bits can reach the converter.
   assign start_bits = (first_ff && nbits_i < dac_link_pkg::WORD_W) ?
                       dac_link_pkg::BITS_W'(dac_link_pkg::WORD_W) : nbits_i;

   // -------------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------------
   always_comb begin
      unique case (state_ff)
         dac_link_pkg::HOST_SETUP: limit = dac_link_pkg::CNT_W'(dac_link_pkg::SETUP_CYC - 1);
         dac_link_pkg::HOST_HOLD: limit = dac_link_pkg::CNT_W'(dac_link_pkg::HOLD_CYC - 1);
         dac_link_pkg::HOST_STROBE: limit = dac_link_pkg::CNT_W'(dac_link_pkg::STROBE_CYC - 1);
         default: limit = dac_link_pkg::CNT_W'(dac_link_pkg::SCLK_HALF_CYC - 1);
      endcase
   end

   assign timer_done = (cnt_ff == limit);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         dac_link_pkg::HOST_IDLE: begin
            if (start_i) begin
               nxt_state = dac_link_pkg::HOST_SETUP;
            end else if (strobe_i) begin
               nxt_state = dac_link_pkg::HOST_STROBE;
            end
         end
         dac_link_pkg::HOST_SETUP: begin
            if (timer_done) begin
               nxt_state = (bits_ff == '0) ? dac_link_pkg::HOST_HOLD : dac_link_pkg::HOST_LOW;
            end
         end
         dac_link_pkg::HOST_LOW: begin
            if (timer_done) begin
               nxt_state = dac_link_pkg::HOST_HIGH;
            end
         end
         dac_link_pkg::HOST_HIGH: begin
            if (timer_done) begin
               nxt_state = (bits_ff == dac_link_pkg::BITS_W'(1)) ? dac_link_pkg::HOST_HOLD : dac_link_pkg::HOST_LOW;
            end
         end
         dac_link_pkg::HOST_HOLD, dac_link_pkg::HOST_STROBE: begin
            if (timer_done) begin
               nxt_state = dac_link_pkg::HOST_IDLE;
            end
         end
         default: begin
            nxt_state = dac_link_pkg::HOST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         state_ff <= dac_link_pkg::HOST_IDLE;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= (nxt_state != state_ff) ? '0 : cnt_ff + 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Word and bit count
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         word_ff <= '0;
         bits_ff <= '0;
         first_ff <= 1'b1;
      end else if (state_ff == dac_link_pkg::HOST_IDLE && start_i) begin
         word_ff <= word_i;
         bits_ff <= start_bits;
         first_ff <= 1'b0;
      end else if (state_ff == dac_link_pkg::HOST_HIGH && timer_done) begin
         bits_ff <= bits_ff - 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Link pins
   // -------------------------------------------------------------------------
   // One chip select only; several devices need an outside decoder.
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         cs_n_ff <= 1'b1;
      end else if (state_ff == dac_link_pkg::HOST_SETUP && timer_done) begin
         cs_n_ff <= 1'b0;
      end else if (state_ff == dac_link_pkg::HOST_HOLD && timer_done) begin
         cs_n_ff <= 1'b1;
      end
   end

   // The serial clock idles low and only toggles inside a frame.
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         sclk_ff <= 1'b0;
      end else begin
         sclk_ff <= (nxt_state == dac_link_pkg::HOST_HIGH);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         din_ff <= 1'b0;
      end else if (nxt_state == dac_link_pkg::HOST_LOW && state_ff != dac_link_pkg::HOST_LOW) begin
         // Leaving the high phase the count still includes the bit just sent.
         din_ff <= bit_at(word_ff, (state_ff == dac_link_pkg::HOST_HIGH) ? bits_ff - 2'd2 : bits_ff - 1'b1);
      end
   end

   // The strobe level is set during setup, ahead of the chip select fall.
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ls_n_ff <= 1'b1;
      end else if (state_ff == dac_link_pkg::HOST_IDLE && start_i) begin
         ls_n_ff <= defer_i;
      end else if (state_ff == dac_link_pkg::HOST_IDLE && strobe_i) begin
         ls_n_ff <= 1'b0;
      end else if (nxt_state == dac_link_pkg::HOST_IDLE) begin
         ls_n_ff <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= (state_ff != dac_link_pkg::HOST_IDLE) && (nxt_state == dac_link_pkg::HOST_IDLE);
      end
   end

   assign link.cs_n = cs_n_ff;
   assign link.sclk = sclk_ff;
   assign link.din = din_ff;
   assign link.load_strobe_n = ls_n_ff;
   assign busy_o = (state_ff != dac_link_pkg::HOST_IDLE);
   assign done_o = done_ff;

endmodule : dac_host_end

// file: core/dac_link_if.sv
`timescale 1ns/1ns
interface dac_link_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic load_strobe_n;

   modport host (
      output cs_n,
      output sclk,
      output din,
      output load_strobe_n
   );

   modport device (
      input cs_n,
      input sclk,
      input din,
      input load_strobe_n
   );
endinterface : dac_link_if

// file: core/dac_link_pkg.sv
package dac_link_pkg;

   // -------------------------------------------------------------------------
   // Word layout
   // -------------------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int SEG_IN_W = 4;
   localparam int SEG_N = 15;
   localparam int LADDER_W = 12;
   localparam int BITS_W = 6;
   localparam logic [WORD_W-1:0] CODE_RESET = 16'h0000;
   localparam logic [SEG_N-1:0] SEG_RESET = 15'h0000;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int SYS_PERIOD_NS = 8;
   localparam int SCLK_MAX_MHZ = 50;
   localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
   // Half period rounded up so the serial clock never runs above its limit.
   localparam int SCLK_HALF_CYC = (SCLK_MIN_PERIOD_NS + 2 * SYS_PERIOD_NS - 1) / (2 * SYS_PERIOD_NS);
   localparam int SETUP_CYC = 4;
   localparam int HOLD_CYC = 4;
   localparam int STROBE_CYC = 4;
   localparam int CNT_W = 4;

   // -------------------------------------------------------------------------
   // State machines
   // -------------------------------------------------------------------------
   typedef enum logic [3:0] {
      DEV_IDLE = 4'h1,
      DEV_FRAME_NOW = 4'h2,
      DEV_FRAME_LATER = 4'h4,
      DEV_PENDING = 4'h8
   } dev_state_type;

   typedef enum logic [5:0] {
      HOST_IDLE = 6'h01,
      HOST_SETUP = 6'h02,
      HOST_LOW = 6'h04,
      HOST_HIGH = 6'h08,
      HOST_HOLD = 6'h10,
      HOST_STROBE = 6'h20
   } host_state_type;

endpackage : dac_link_pkg

// file: core/seg_decoder.sv
`timescale 1ns/1ns
module seg_decoder (
   input wire logic [dac_link_pkg::SEG_IN_W-1:0] top_i,
   output logic [dac_link_pkg::SEG_N-1:0] seg_o
);
   // Thermometer code: switch k closes when the top bits exceed k.
   for (genvar k = 0; k < dac_link_pkg::SEG_N; k++) begin : g_seg
      assign seg_o[k] = (top_i > dac_link_pkg::SEG_IN_W'(k));
   end
endmodule : seg_decoder

// file: dv/dac_serial_load_control_props.sv
`timescale 1ns/1ns
module dac_serial_load_control_props (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic load_strobe_n,
   input wire logic [dac_link_pkg::WORD_W-1:0] code_o,
   input wire logic update_o,
   input wire logic pending_o,
   input wire logic frame_o
);
   logic mode_ff;
   logic [3:0] since_ff;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);

   // -------------------------------------------------------------------------
   // Helper logic
   // -------------------------------------------------------------------------
   // The strobe level seen at the frame opening decides the load mode.
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         mode_ff <= 1'b1;
      end else if ($fell(cs_n)) begin
         mode_ff <= load_strobe_n;
      end
   end

   // Cycles since the last possible cause of a transfer, saturating.
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         since_ff <= 4'hf;
      end else if ($rose(cs_n) || $fell(load_strobe_n)) begin
         since_ff <= 4'h0;
      end else if (since_ff != 4'hf) begin
         since_ff <= since_ff + 4'h1;
      end
   end

   // -------------------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------------------
   sequence s_open;
      $fell(cs_n);
   endsequence

   sequence s_close;
      $rose(cs_n);
   endsequence

   property p_sclk_idle;
      cs_n |-> !sclk;
   endproperty
   property p_strobe_steady;
      !cs_n && !$past(cs_n) |-> $stable(load_strobe_n);
   endproperty
   property p_frame_seen;
      s_open |-> ##[1:5] frame_o;
   endproperty
   property p_cs_gap;
      s_close |=> cs_n [*4];
   endproperty
   property p_instant;
      s_close ##0 !mode_ff |-> ##[3:8] update_o;
   endproperty
   property p_defer;
      s_close ##0 mode_ff |-> (!update_o) throughout (##[3:8] pending_o);
   endproperty
   property p_strobe_load;
      $fell(load_strobe_n) && cs_n && pending_o |-> ##[3:8] update_o;
   endproperty
   property p_update_cause;
      update_o |-> since_ff <= 4'h9;
   endproperty
   property p_code_hold;
      $changed(code_o) |-> update_o;
   endproperty
   property p_reset_clear;
      disable iff (1'b0) !resetn_i |=> code_o == 16'h0000 && !update_o && !pending_o;
   endproperty

   a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock high outside a frame");
   a_strobe_steady: assert property (p_strobe_steady) else $error("strobe moved inside a frame");
   a_frame_seen: assert property (p_frame_seen) else $error("frame not seen after chip select fall");
   a_cs_gap: assert property (p_cs_gap) else $error("chip select gap too short");
   a_instant: assert property (p_instant) else $error("no update at frame close");
   a_defer: assert property (p_defer) else $error("deferred word not held pending");
   a_strobe_load: assert property (p_strobe_load) else $error("strobe fall did not load pending word");
   a_update_cause: assert property (p_update_cause) else $error("update without a cause");
   a_code_hold: assert property (p_code_hold) else $error("code changed without update");
   a_reset_clear: assert property (p_reset_clear) else $error("code not cleared by reset");
endmodule : dac_serial_load_control_props

// file: dv/dac_serial_load_control_tb.sv
`timescale 1ns/1ns
module dac_serial_load_control_tb;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic start_i = 1'b0;
   logic defer_i = 1'b0;
   logic strobe_i = 1'b0;
   logic [15:0] word_i = 16'h0000;
   logic [5:0] nbits_i = 6'h00;
   logic busy_o, done_o, update_o, pending_o, frame_o, pending_b;
   logic [15:0] code_o, code_b;
   logic [14:0] seg_o;
   logic [11:0] ladder_o;
   int num_errors = 0;
   int n_tests = 0;

   dac_link_if link_a();
   dac_link_if link_b();

   always #4 sys_clk_i = ~sys_clk_i;

   dac_host_end u_dac_host_end (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .link(link_a), .start_i(start_i),
      .word_i(word_i), .nbits_i(nbits_i), .defer_i(defer_i), .strobe_i(strobe_i), .busy_o(busy_o), .done_o(done_o));
   dac_device_end u_dac_device_end (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .link(link_a), .code_o(code_o),
      .seg_o(seg_o), .ladder_o(ladder_o), .update_o(update_o), .pending_o(pending_o), .frame_o(frame_o));
   // A second device faces the bench directly so that host faults can be forced.
   dac_device_end u_dac_device_end_b (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .link(link_b), .code_o(code_b),
      .seg_o(), .ladder_o(), .update_o(), .pending_o(pending_b), .frame_o());
   dac_serial_load_control_props u_dac_serial_load_control_props (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .cs_n(link_a.cs_n), .sclk(link_a.sclk), .din(link_a.din), .load_strobe_n(link_a.load_strobe_n),
      .code_o(code_o), .update_o(update_o), .pending_o(pending_o), .frame_o(frame_o));

   // -------------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------------
   task report_and_stop;
      if (num_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   task chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t word got %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task chk_flag(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t flag got %b expected %b", $time, got, exp);
      end
   endtask : chk_flag

   function automatic logic [14:0] seg_of(input logic [15:0] w);
      logic [14:0] s;
      for (int k = 0; k < 15; k++) begin
         s[k] = (int'(w[15:12]) > k);
      end
      return s;
   endfunction : seg_of

   task chk_out(input logic [15:0] exp);
      chk_word(code_o, exp);
      chk_word({4'h0, ladder_o}, {4'h0, exp[11:0]});
      chk_word({1'b0, seg_o}, {1'b0, seg_of(exp)});
   endtask : chk_out

   // A frame's transfer lands a few cycles after done; 12 cycles leave margin for it.
   task wait_done;
      int i;
      i = 0;
      while (done_o !== 1'b1) begin
         @(negedge sys_clk_i);
         i++;
         if (i > 500) begin
            num_errors++;
            $display("MISMATCH %0t host never finished", $time);
            report_and_stop();
         end
      end
      repeat (12) @(negedge sys_clk_i);
      chk_flag(busy_o, 1'b0);
   endtask : wait_done

   task host_frame(input logic [15:0] w, input logic [5:0] n, input logic d);
      start_i = 1'b1;
      word_i = w;
      nbits_i = n;
      defer_i = d;
      @(negedge sys_clk_i);
      start_i = 1'b0;
      chk_flag(busy_o, 1'b1);
      wait_done();
   endtask : host_frame

   task host_strobe;
      strobe_i = 1'b1;
      @(negedge sys_clk_i);
      strobe_i = 1'b0;
      chk_flag(busy_o, 1'b1);
      wait_done();
   endtask : host_strobe

   // Serial clock of 15 ns; data is released to its inverse afterwards.
   task bb_bits(input logic [15:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         link_b.din = w[i];
         #8 link_b.sclk = 1'b1;
         #7 link_b.sclk = 1'b0;
      end
      link_b.din = ~link_b.din;
   endtask : bb_bits

   task bb_frame(input logic [15:0] w, input int n, input logic glitch);
      link_b.cs_n = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      bb_bits(w, n);
      if (glitch) begin
         repeat (4) @(negedge sys_clk_i);
         link_b.load_strobe_n = 1'b0;
         repeat (4) @(negedge sys_clk_i);
         link_b.load_strobe_n = 1'b1;
      end
      repeat (4) @(negedge sys_clk_i);
      link_b.cs_n = 1'b1;
      repeat (12) @(negedge sys_clk_i);
   endtask : bb_frame

   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial begin
      link_b.cs_n = 1'b1;
      link_b.sclk = 1'b0;
      link_b.din = 1'b0;
      link_b.load_strobe_n = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      chk_word(code_o, 16'h0000);
      chk_flag(pending_o, 1'b0);
      host_strobe();
      chk_word(code_o, 16'h0000);
      host_frame(16'ha5c3, 6'd4, 1'b0);
      chk_out(16'ha5c3);
      host_frame(16'h1234, 6'd20, 1'b0);
      chk_out(16'h1234);
      host_frame(16'h00ab, 6'd8, 1'b0);
      chk_out(16'h34ab);
      host_frame(16'hfedc, 6'd16, 1'b1);
      chk_out(16'h34ab);
      chk_flag(pending_o, 1'b1);
      host_strobe();
      chk_out(16'hfedc);
      chk_flag(pending_o, 1'b0);
      host_strobe();
      chk_out(16'hfedc);
      for (int k = 0; k < 16; k++) begin
         host_frame({k[3:0], 12'h5a5}, 6'd16, 1'b0);
         chk_out({k[3:0], 12'h5a5});
      end
      bb_frame(16'h1357, 16, 1'b0);
      chk_word(code_b, 16'h1357);
      bb_bits(16'hffff, 8);
      @(negedge sys_clk_i);
      bb_frame(16'h0000, 8, 1'b0);
      chk_word(code_b, 16'h5700);
      link_b.load_strobe_n = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      bb_frame(16'h2468, 16, 1'b0);
      bb_frame(16'h9bdf, 16, 1'b1);
      chk_word(code_b, 16'h5700);
      chk_flag(pending_b, 1'b1);
      link_b.load_strobe_n = 1'b0;
      repeat (12) @(negedge sys_clk_i);
      chk_word(code_b, 16'h9bdf);
      report_and_stop();
   end
endmodule : dac_serial_load_control_tb
